// *** verilog/pmc_regs.sv ***
// power-management capability registers and bridge control tail, ahb-lite
// What this block does
// - forward secondary system error only when both enables are set
// - parity response enable is a plain read/write bit with no effect
// - byte at 50h reads 01h, the power-management capability id
// - byte at 51h reads 70h, linking to the next capability
// - wake state mask bits 15:11 read y11x1
// - bit 15 follows the standby supply present control bit
// - bit 9 and mask D1 bit follow the Low_power_state1_supported control bit
// - bit 10 reads constant 1, D2 supported
// - bits 8:6 read zero, no standby current
// - bit 5 reads 0, no special initialisation
// - reserved bit 4 reads zero
// - bit 3 reads 0, no bus clock needed for wake
// - bits 2:0 read 011
`default_nettype none
module pmc_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // system error path
  input  wire logic        cmd_serr_enable,
  input  wire logic        secondary_serr,
  output logic             upstream_serr,
  // control outputs
  output logic             parity_response_enable
);
  pmc_pkg::pmc_req_t   req_q;
  pmc_pkg::pmc_global_t glb;
  logic [15:0]         caps;
  logic                serr_fwd_q;
  logic                system_error_forward_enable;
  logic                we_bridge;
  logic                we_global;
  logic [31:0]         rdata_d;
  logic [31:0]         hrdata_q;
  logic                serr_out_q;
  logic                rd_phase;
  logic                pm_read;

  // address phase capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_q <= '0;
    end else if (hready) begin
      req_q.valid <= hsel && (htrans == pmc_pkg::HTRANS_NONSEQ);
      req_q.sel   <= hsel;
      req_q.addr  <= {haddr[7:2], 2'b00};
      req_q.write <= hwrite;
    end else begin
      req_q.valid <= 1'b0;
    end
  end

  // writes only land in own registers
  assign we_bridge = req_q.valid && req_q.write
                     && (req_q.addr == pmc_pkg::BRIDGE_CTL_ADDR);
  assign we_global = req_q.valid && req_q.write
                     && (req_q.addr == pmc_pkg::GLOBAL_CTL_ADDR);

  pmc_ctl_bit #(.RST_VAL(pmc_pkg::BRIDGE_CTL_RST[pmc_pkg::PARITY_RESP_BIT]))
    u_parity (
    .clk  (clk),
    .rst_n(rst_n),
    .we   (we_bridge),
    .wdata(hwdata[pmc_pkg::PARITY_RESP_BIT]),
    .q    (parity_response_enable)
  );

  pmc_ctl_bit #(.RST_VAL(pmc_pkg::BRIDGE_CTL_RST[pmc_pkg::SERR_FWD_BIT]))
    u_serr (
    .clk  (clk),
    .rst_n(rst_n),
    .we   (we_bridge),
    .wdata(hwdata[pmc_pkg::SERR_FWD_BIT]),
    .q    (serr_fwd_q)
  );
  assign system_error_forward_enable = serr_fwd_q;

  pmc_ctl_bit #(.RST_VAL(pmc_pkg::STBY_SUPPLY_RST)) u_stby (
    .clk  (clk),
    .rst_n(rst_n),
    .we   (we_global),
    .wdata(hwdata[pmc_pkg::STBY_SUPPLY_BIT]),
    .q    (glb.standby_supply_present)
  );

  // low_power_state1_supported mirror, reset follows its default
  pmc_ctl_bit #(.RST_VAL(pmc_pkg::D1_SUPP_RST)) u_d1 (
    .clk  (clk),
    .rst_n(rst_n),
    .we   (we_global),
    .wdata(hwdata[pmc_pkg::D1_SUPP_CTL_BIT]),
    .q    (glb.d1_supported)
  );

  pmc_caps_word u_caps (
    .glb (glb),
    .caps(caps)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serr_out_q <= 1'b0;
    end else begin
      serr_out_q <= system_error_forward_enable && cmd_serr_enable
                    && secondary_serr;
    end
  end
  assign upstream_serr = serr_out_q;

  // read mux, decoded from the address phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case ({haddr[7:2], 2'b00})
      pmc_pkg::PM_WORD_ADDR: begin
        rdata_d = {caps, pmc_pkg::NEXT_LINK_VAL, pmc_pkg::CAP_ID_VAL};
      end
      pmc_pkg::BRIDGE_CTL_ADDR: begin
        rdata_d[pmc_pkg::PARITY_RESP_BIT] = parity_response_enable;
        rdata_d[pmc_pkg::SERR_FWD_BIT]    = serr_fwd_q;
      end
      pmc_pkg::GLOBAL_CTL_ADDR: begin
        rdata_d[pmc_pkg::STBY_SUPPLY_BIT] = glb.standby_supply_present;
        rdata_d[pmc_pkg::D1_SUPP_CTL_BIT] = glb.d1_supported;
      end
      pmc_pkg::STATUS_ADDR: begin
        rdata_d[0] = serr_out_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // read address phase; idle slots leave hrdata alone
  assign rd_phase = hready && hsel && !hwrite
                    && (htrans == pmc_pkg::HTRANS_NONSEQ);
  assign pm_read  = rd_phase
                    && ({haddr[7:2], 2'b00} == pmc_pkg::PM_WORD_ADDR);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_phase) begin
      hrdata_q <= rdata_d;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // checks
  property p_serr_fwd;
    @(posedge clk) disable iff (!rst_n)
    (system_error_forward_enable && cmd_serr_enable && secondary_serr)
      |=> upstream_serr;
  endproperty
  a_serr_fwd: assert property (p_serr_fwd)
    else $error("serr not forwarded");

  property p_serr_block;
    @(posedge clk) disable iff (!rst_n)
    !$past(system_error_forward_enable) |-> !upstream_serr;
  endproperty
  a_serr_block: assert property (p_serr_block)
    else $error("serr forwarded while disabled");

  property p_parity_hold;
    @(posedge clk) disable iff (!rst_n)
    we_bridge |=> parity_response_enable
                  == $past(hwdata[pmc_pkg::PARITY_RESP_BIT]);
  endproperty
  a_parity_hold: assert property (p_parity_hold)
    else $error("parity bit not stored");

  property p_id_bytes;
    @(posedge clk) disable iff (!rst_n)
    pm_read |=> (hrdata[15:0] == 16'h7001);
  endproperty
  a_id_bytes: assert property (p_id_bytes)
    else $error("capability id or link wrong");

  property p_wake_mask;
    @(posedge clk) disable iff (!rst_n)
    caps[14:13] == 2'b11 && caps[11] && caps[12] == glb.d1_supported;
  endproperty
  a_wake_mask: assert property (p_wake_mask)
    else $error("wake mask pattern wrong");

  property p_d3cold;
    @(posedge clk) disable iff (!rst_n)
    we_global |=> caps[15] == $past(hwdata[pmc_pkg::STBY_SUPPLY_BIT]);
  endproperty
  a_d3cold: assert property (p_d3cold)
    else $error("d3cold bit does not follow standby supply");

  property p_d1;
    @(posedge clk) disable iff (!rst_n)
    we_global |=> caps[9] == $past(hwdata[pmc_pkg::D1_SUPP_CTL_BIT]);
  endproperty
  a_d1: assert property (p_d1)
    else $error("low_power_state1_supported bit does not follow control");

  property p_low_fields;
    @(posedge clk) disable iff (!rst_n)
    caps[10] && caps[8:0] == 9'h003;
  endproperty
  a_low_fields: assert property (p_low_fields)
    else $error("fixed capability bits wrong");

  property p_ro_write;
    @(posedge clk) disable iff (!rst_n)
    (req_q.valid && req_q.write && req_q.addr == pmc_pkg::PM_WORD_ADDR)
      |=> $stable(caps);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("read-only word changed by write");

  // bus-level checks: fields as software reads them, plus reset values of the global mirrors
  property p_next_link;
    @(posedge clk) disable iff (!rst_n)
    pm_read |=> hrdata[15:8] == 8'h70;
  endproperty
  a_next_link: assert property (p_next_link)
    else $error("next capability link wrong");

  property p_rd_wake_fixed;
    @(posedge clk) disable iff (!rst_n)
    pm_read |=> hrdata[30:29] == 2'b11 && hrdata[27];
  endproperty
  a_rd_wake_fixed: assert property (p_rd_wake_fixed)
    else $error("wake mask fixed ones not read back");

  property p_rd_d3cold;
    @(posedge clk) disable iff (!rst_n)
    pm_read |=> hrdata[31] == $past(glb.standby_supply_present);
  endproperty
  a_rd_d3cold: assert property (p_rd_d3cold)
    else $error("d3cold bit read back wrong");

  property p_rd_d1;
    @(posedge clk) disable iff (!rst_n)
    pm_read |=> hrdata[28] == $past(glb.d1_supported)
                && hrdata[25] == $past(glb.d1_supported);
  endproperty
  a_rd_d1: assert property (p_rd_d1)
    else $error("d1 bits read back wrong");

  property p_rd_d2;
    @(posedge clk) disable iff (!rst_n)
    pm_read |=> hrdata[26];
  endproperty
  a_rd_d2: assert property (p_rd_d2)
    else $error("low_power_state2_supported bit not set");

  property p_rd_stby_cur;
    @(posedge clk) disable iff (!rst_n)
    pm_read |=> hrdata[24:22] == 3'b000;
  endproperty
  a_rd_stby_cur: assert property (p_rd_stby_cur)
    else $error("standby current field not zero");

  property p_rd_spec_init;
    @(posedge clk) disable iff (!rst_n)
    pm_read |=> !hrdata[21];
  endproperty
  a_rd_spec_init: assert property (p_rd_spec_init)
    else $error("special init bit set");

  property p_rd_rsvd4;
    @(posedge clk) disable iff (!rst_n)
    pm_read |=> !hrdata[20];
  endproperty
  a_rd_rsvd4: assert property (p_rd_rsvd4)
    else $error("reserved bit 4 set");

  property p_rd_wake_clk;
    @(posedge clk) disable iff (!rst_n)
    pm_read |=> !hrdata[19];
  endproperty
  a_rd_wake_clk: assert property (p_rd_wake_clk)
    else $error("wake clock bit set");

  property p_rd_rev;
    @(posedge clk) disable iff (!rst_n)
    pm_read |=> hrdata[18:16] == 3'b011;
  endproperty
  a_rd_rev: assert property (p_rd_rev)
    else $error("revision field wrong");

  property p_d1_rst;
    @(posedge clk)
    !rst_n |=> glb.d1_supported == pmc_pkg::D1_SUPP_RST;
  endproperty
  a_d1_rst: assert property (p_d1_rst)
    else $error("low_power_state1_supported reset value wrong");

  property p_stby_rst;
    @(posedge clk)
    !rst_n |=> glb.standby_supply_present == pmc_pkg::STBY_SUPPLY_RST;
  endproperty
  a_stby_rst: assert property (p_stby_rst)
    else $error("standby supply reset value wrong");

  property p_rd_bridge;
    @(posedge clk) disable iff (!rst_n)
    (rd_phase
     && ({haddr[7:2], 2'b00} == pmc_pkg::BRIDGE_CTL_ADDR))
      |=> hrdata[0] == $past(parity_response_enable)
          && hrdata[1] == $past(serr_fwd_q);
  endproperty
  a_rd_bridge: assert property (p_rd_bridge)
    else $error("bridge control read back wrong");

  property p_hrdata_hold;
    @(posedge clk) disable iff (!rst_n)
    !rd_phase |=> $stable(hrdata);
  endproperty
  a_hrdata_hold: assert property (p_hrdata_hold)
    else $error("read data changed without a read");
endmodule
`default_nettype wire

// *** verilog/pmc_pkg.sv ***
// package: register map, field layout and bus types for the pm capability block
`default_nettype none
package pmc_pkg;
  // configuration offsets (byte addresses of the printed registers)
  localparam logic [7:0] CAP_ID_OFF     = 8'h50;
  localparam logic [7:0] NEXT_LINK_OFF  = 8'h51;
  localparam logic [7:0] CAPS_WORD_OFF  = 8'h52;
  // word holding the three registers above
  localparam logic [7:0] PM_WORD_ADDR   = 8'h50;
  // own registers: bridge control tail, global control mirrors and serr status
  localparam logic [7:0] BRIDGE_CTL_ADDR = 8'h60;
  localparam logic [7:0] GLOBAL_CTL_ADDR = 8'h64;
  localparam logic [7:0] STATUS_ADDR     = 8'h68;
  // fixed values
  localparam logic [7:0] CAP_ID_VAL     = 8'h01;
  localparam logic [7:0] NEXT_LINK_VAL  = 8'h70;
  localparam logic [2:0] PM_REV_VAL     = 3'h3;
  localparam logic [2:0] STBY_CUR_VAL   = 3'h0;
  // capabilities word field positions
  localparam int WAKE_D3COLD_BIT = 15;
  localparam int WAKE_D3HOT_BIT  = 14;
  localparam int WAKE_D2_BIT     = 13;
  localparam int WAKE_D1_BIT     = 12;
  localparam int WAKE_D0_BIT     = 11;
  localparam int D2_SUPP_BIT     = 10;
  localparam int D1_SUPP_BIT     = 9;
  localparam int STBY_CUR_LSB    = 6;
  localparam int SPEC_INIT_BIT   = 5;
  localparam int RSVD4_BIT       = 4;
  localparam int WAKE_CLK_BIT    = 3;
  localparam int PM_REV_LSB      = 0;
  // bridge control and global control bit positions
  localparam int PARITY_RESP_BIT = 0;
  localparam int SERR_FWD_BIT    = 1;
  localparam int STBY_SUPPLY_BIT = 0;
  localparam int D1_SUPP_CTL_BIT = 1;
  // reset values
  localparam logic [1:0] BRIDGE_CTL_RST = 2'h0;
  localparam logic       STBY_SUPPLY_RST = 1'b0;
  localparam logic       D1_SUPP_RST     = 1'b0;
  // ahb-lite transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic       sel;
    logic [7:0] addr;
    logic       write;
    logic       valid;
  } pmc_req_t;

  typedef struct packed {
    logic standby_supply_present;
    logic d1_supported;
  } pmc_global_t;
endpackage
`default_nettype wire

// *** verilog/pmc_ctl_bit.sv ***
// one software-writable control bit with reset value
`default_nettype none
module pmc_ctl_bit #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // write port
  input  wire logic we,
  input  wire logic wdata,
  // stored value
  output logic      q
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RST_VAL;
    end else if (we) begin
      q <= wdata;
    end
  end
endmodule
`default_nettype wire

// *** verilog/pmc_caps_word.sv ***
// builds the read-only power-management capabilities word
`default_nettype none
module pmc_caps_word (
  // mirrored global control bits
  input  wire pmc_pkg::pmc_global_t glb,
  // assembled word
  output logic [15:0]               caps
);
  always_comb begin
    caps = 16'h0000;
    caps[pmc_pkg::WAKE_D3COLD_BIT] = glb.standby_supply_present;
    caps[pmc_pkg::WAKE_D3HOT_BIT]  = 1'b1;
    caps[pmc_pkg::WAKE_D2_BIT]     = 1'b1;
    caps[pmc_pkg::WAKE_D1_BIT]     = glb.d1_supported;
    caps[pmc_pkg::WAKE_D0_BIT]     = 1'b1;
    caps[pmc_pkg::D2_SUPP_BIT]     = 1'b1;
    caps[pmc_pkg::D1_SUPP_BIT]     = glb.d1_supported;
    caps[pmc_pkg::STBY_CUR_LSB +: 3] = pmc_pkg::STBY_CUR_VAL;
    caps[pmc_pkg::SPEC_INIT_BIT]   = 1'b0;
    caps[pmc_pkg::RSVD4_BIT]       = 1'b0;
    caps[pmc_pkg::WAKE_CLK_BIT]    = 1'b0;
    caps[pmc_pkg::PM_REV_LSB +: 3] = pmc_pkg::PM_REV_VAL;
  end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the pm capability register block
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("FAIL %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic        hsel      = 1'b0;
  logic [7:0]  haddr     = 8'h00;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic        cmd_en    = 1'b0;
  logic        sec_serr  = 1'b0;
  wire  logic  hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        up_serr;
  logic        parity_en;
  logic [31:0] rd;
  int          failures  = 0;
  int          compares  = 0;
  int          cycles    = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  pmc_regs u_dut (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .hsel                   (hsel),
    .haddr                  (haddr),
    .htrans                 (htrans),
    .hwrite                 (hwrite),
    .hsize                  (hsize),
    .hwdata                 (hwdata),
    .hready                 (hready),
    .hrdata                 (hrdata),
    .hreadyout              (hreadyout),
    .hresp                  (hresp),
    .cmd_serr_enable        (cmd_en),
    .secondary_serr         (sec_serr),
    .upstream_serr          (up_serr),
    .parity_response_enable (parity_en)
  );

  always #50 clk = ~clk;

  task automatic summarize();
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard, under two hundred cycles of traffic expected
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end

  // one whole-word transfer; entered just after a rising edge
  task automatic bus(input logic [7:0] a, input logic wr,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= pmc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
    `CHK("hresp", 1'h0, hresp)
    `CHK("hreadyout", 1'h1, hreadyout)
  endtask

  // expected capabilities word: y11x1, d2, x, then fixed low bits
  function automatic logic [15:0] cw(input logic y, input logic x);
    return {y, 1'h1, 1'h1, x, 1'h1, 1'h1, x, 3'h0, 1'h0, 1'h0,
            1'h0, 3'h3};
  endfunction

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("parity reset", 1'h0, parity_en)
    `CHK("serr reset", 1'h0, up_serr)
    bus(8'h50, 1'b0, 32'h0000_0000, rd);
    `CHK("pm word reset", {cw(1'h0, 1'h0), 16'h7001}, rd)
    // mirrored global bits, every combination
    for (int g = 0; g < 4; g++) begin
      bus(8'h64, 1'b1, {30'h0, g[1], g[0]}, rd);
      bus(8'h64, 1'b0, 32'h0000_0000, rd);
      `CHK("global ctl", {30'h0, g[1], g[0]}, rd)
      bus(8'h50, 1'b0, 32'h0000_0000, rd);
      `CHK("pm word", {cw(g[0], g[1]), 16'h7001}, rd)
    end
    // read-only word ignores writes
    bus(8'h50, 1'b1, 32'hFFFF_FFFF, rd);
    bus(8'h50, 1'b0, 32'h0000_0000, rd);
    `CHK("pm word ro", {cw(1'h1, 1'h1), 16'h7001}, rd)
    bus(8'h7C, 1'b0, 32'h0000_0000, rd);
    `CHK("unmapped", 32'h0000_0000, rd)
    // forward gating across all enable and error combinations
    for (int i = 0; i < 16; i++) begin
      bus(8'h60, 1'b1, {30'h0, i[2], i[3]}, rd);
      cmd_en <= i[1];
      sec_serr <= i[0];
      @(posedge clk);
      @(posedge clk);
      `CHK("upstream serr", i[2] & i[1] & i[0], up_serr)
      `CHK("parity bit", i[3], parity_en)
      bus(8'h60, 1'b0, 32'h0000_0000, rd);
      `CHK("bridge ctl", {30'h0, i[2], i[3]}, rd)
      bus(8'h68, 1'b0, 32'h0000_0000, rd);
      `CHK("serr status", {31'h0, i[2] & i[1] & i[0]}, rd)
    end
    bus(8'h50, 1'b0, 32'h0000_0000, rd);
    `CHK("pm word stable", {cw(1'h1, 1'h1), 16'h7001}, rd)
    summarize();
  end
endmodule
`default_nettype wire
